// ===== hdl/btts_pkg.sv
/*
 * Constants, register map and carrier types of the bus trace trigger sequencer.
 * Assumes a single clock that ticks once per observed target bus cycle slot.
 */
//
// Overview of operation
// - Self-arming default: arm at program start, disarm after program stops.
// - Circular mode keeps overwriting so newest cycles before the stop remain.
// - Fill-once mode stops recording when the buffer becomes full.
// - Run-only sampling default: sample cycles only while the program runs.
// - Edge-cycle capture default: first sampled cycle after arming and the cycle ending it by trigger, post count or fill always stored.
// - Buffer holds 32676 records by default.
// - Without loaded trigger configuration every bus cycle is recorded.
// - Three trigger groups, each with its own disable.
// - Each group selects reads, writes or both by two bits.
// - Address term: ignored, single address, or inclusive start..end range.
// - Data term compares mask-one bits with reference; can be disabled.
// - External term: 8-bit reference and mask on port A or B; can be disabled.
// - Sequencer offers exactly six recording modes.
// - All-cycles mode stores every cycle; post count ends it when enabled.
// - Events-only mode stores matching cycles; post count ends it when enabled.
// - Guarded mode: first then third group without second; second restarts.
// - Any-event mode stops on any group match, or after post count.
// - Three-step mode stops after first, second, third in order, or post count.
// - Either-then mode: first or second match, then third match stops.
// - With post counting, record the configured cycles after the stop, then end.
// - Stop-on-termination option requests a target halt when recording ends.
// - Manual disarm stops collection without halting the target.

package btts_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int EXT_W = 8;
  localparam int TAG_W = 15;
  localparam int NGRP = 3;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_POST = 8'h0C;
  localparam logic [7:0] OFS_RD_IDX = 8'h10;
  localparam logic [7:0] OFS_REC_LO = 8'h14;
  localparam logic [7:0] OFS_REC_HI = 8'h18;
  localparam logic [7:0] OFS_WR_PTR = 8'h1C;
  localparam logic [7:0] OFS_GRP_BASE = 8'h40;
  localparam logic [7:0] GRP_STRIDE = 8'h10;
  localparam logic [3:0] OFS_G_CTRL = 4'h0;
  localparam logic [3:0] OFS_G_ADDR = 4'h4;
  localparam logic [3:0] OFS_G_DATA = 4'h8;

  // ---------------------------------------------------------------------------
  // CTRL fields
  // ---------------------------------------------------------------------------
  localparam int CTRL_SELF_ARM = 0;
  localparam int CTRL_FILL_ONCE = 1;
  localparam int CTRL_RUN_ONLY = 2;
  localparam int CTRL_EDGE_CAP = 3;
  localparam int CTRL_POST_EN = 4;
  localparam int CTRL_STOP_PROG = 5;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_LOADED = 9;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h00D;

  // CMD fields (write one to act)
  localparam int CMD_ARM = 0;
  localparam int CMD_DISARM = 1;

  // STATUS fields
  localparam int STAT_ARMED = 0;
  localparam int STAT_REC = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_TRIG = 3;
  localparam int STAT_WRAP = 4;
  localparam int STAT_COUNT_LO = 16;

  // ---------------------------------------------------------------------------
  // Per-group CTRL fields
  // ---------------------------------------------------------------------------
  localparam int G_DIS = 0;
  localparam int G_RD = 1;
  localparam int G_WR = 2;
  localparam int G_AMODE_LO = 3;
  localparam int G_DDIS = 5;
  localparam int G_EXT_LO = 6;
  localparam int G_EREF_LO = 8;
  localparam int G_EMASK_LO = 16;
  localparam logic [31:0] G_CTRL_RESET = 32'h0000_0001;

  typedef enum logic [1:0] {
    AM_OFF = 2'h0,
    AM_SINGLE = 2'h1,
    AM_RANGE = 2'h2
  } btts_amode_t;

  typedef enum logic [1:0] {
    EX_OFF = 2'h0,
    EX_A = 2'h1,
    EX_B = 2'h2
  } btts_ext_t;

  typedef enum logic [2:0] {
    MD_ALL = 3'h0,
    MD_EVENTS = 3'h1,
    MD_A_C_NOT_B = 3'h2,
    MD_ANY = 3'h3,
    MD_A_B_C = 3'h4,
    MD_AB_C = 3'h5
  } btts_mode_t;

  // Sequencer step, Gray along the usual walk
  typedef enum logic [1:0] {
    SQ_STEP1 = 2'b00,
    SQ_STEP2 = 2'b01,
    SQ_STEP3 = 2'b11,
    SQ_POST = 2'b10
  } btts_seq_t;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic rnw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [EXT_W-1:0] ext_a;
    logic [EXT_W-1:0] ext_b;
  } btts_cycle_t;

  typedef struct packed {
    logic dis;
    logic rd;
    logic wr;
    btts_amode_t amode;
    logic ddis;
    btts_ext_t ext;
    logic [EXT_W-1:0] eref;
    logic [EXT_W-1:0] emask;
    logic [ADDR_W-1:0] astart;
    logic [ADDR_W-1:0] aend;
    logic [DATA_W-1:0] dref;
    logic [DATA_W-1:0] dmask;
  } btts_grp_t;

  typedef struct packed {
    logic rnw;
    logic [TAG_W-1:0] tag;
    logic [EXT_W-1:0] ext_b;
    logic [EXT_W-1:0] ext_a;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } btts_rec_t;

endpackage : btts_pkg

// ===== hdl/btts_top.sv
/*
 * Bus trace trigger sequencer: samples observed bus cycles into a trace
 * buffer, qualifies them with three trigger groups, and ends recording by a
 * six-mode sequencer plus post-trigger counter. Registers on Avalon-MM.
 * Assumes the observed bus and program-run pins are asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module btts_top #(
  parameter int DEPTH = 32676,
  parameter int POST_W = 16
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Observed target bus
  input wire btts_pkg::btts_cycle_t bus_cycle_i,
  input wire logic prog_running_i,
  // Status toward the target side
  output logic halt_req_o,
  output logic recording_o
);

  localparam int IDX_W = $clog2(DEPTH);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);
  localparam logic [IDX_W:0] DEPTH_CNT = (IDX_W+1)'(DEPTH);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  btts_pkg::btts_cycle_t cyc_meta_q, cyc_q;
  logic run_meta_q, run_q, run_prev_q;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      cyc_meta_q <= '0;
      cyc_q <= '0;
      run_meta_q <= 1'b0;
      run_q <= 1'b0;
      run_prev_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      cyc_meta_q <= bus_cycle_i;
      cyc_q <= cyc_meta_q;
      run_meta_q <= prog_running_i;
      run_q <= run_meta_q;
      run_prev_q <= run_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Trigger group evaluation
  // ---------------------------------------------------------------------------
  function automatic logic grp_match(input btts_pkg::btts_grp_t g,
                                     input btts_pkg::btts_cycle_t c);
    logic acc_ok;
    logic adr_ok;
    logic dat_ok;
    logic ext_ok;
    acc_ok = c.rnw ? g.rd : g.wr;
    case (g.amode)
      btts_pkg::AM_SINGLE: adr_ok = (c.addr == g.astart);
      btts_pkg::AM_RANGE: adr_ok = (c.addr >= g.astart) && (c.addr <= g.aend);
      default: adr_ok = 1'b1;
    endcase
    dat_ok = g.ddis || (((c.data ^ g.dref) & g.dmask) == '0);
    case (g.ext)
      btts_pkg::EX_A: ext_ok = (((c.ext_a ^ g.eref) & g.emask) == '0);
      btts_pkg::EX_B: ext_ok = (((c.ext_b ^ g.eref) & g.emask) == '0);
      default: ext_ok = 1'b1;
    endcase
    grp_match = !g.dis && acc_ok && adr_ok && dat_ok && ext_ok;
  endfunction : grp_match

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [btts_pkg::CTRL_W-1:0] ctrl_q;
  logic [POST_W-1:0] post_cfg_q;
  logic [IDX_W-1:0] rd_idx_q;
  btts_pkg::btts_grp_t grp_q [btts_pkg::NGRP];
  logic ack_q;
  logic acc_req;
  logic wr_hit;
  logic cmd_arm;
  logic cmd_disarm;

  assign acc_req = avs_read_i || avs_write_i;
  // One wait state on every access
  assign avs_waitrequest_o = acc_req && !ack_q;
  assign wr_hit = avs_write_i && !ack_q && clk_en_i;
  assign cmd_arm = wr_hit && (avs_address_i == btts_pkg::OFS_CMD)
                   && avs_writedata_i[btts_pkg::CMD_ARM];
  assign cmd_disarm = wr_hit && (avs_address_i == btts_pkg::OFS_CMD)
                      && avs_writedata_i[btts_pkg::CMD_DISARM];

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      ack_q <= 1'b0;
    else if (clk_en_i)
      ack_q <= acc_req && !ack_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_q <= btts_pkg::CTRL_RESET;
      post_cfg_q <= '0;
      rd_idx_q <= '0;
      for (int i = 0; i < btts_pkg::NGRP; i++)
      begin
        // Field order differs from the bus layout, so set by name
        grp_q[i] <= '0;
        grp_q[i].dis <= btts_pkg::G_CTRL_RESET[btts_pkg::G_DIS];
      end
    end
    else if (wr_hit)
    begin
      if (avs_address_i == btts_pkg::OFS_CTRL)
        ctrl_q <= avs_writedata_i[btts_pkg::CTRL_W-1:0];
      else if (avs_address_i == btts_pkg::OFS_POST)
        post_cfg_q <= avs_writedata_i[POST_W-1:0];
      else if (avs_address_i == btts_pkg::OFS_RD_IDX)
        rd_idx_q <= avs_writedata_i[IDX_W-1:0];
      else
      begin
        for (int i = 0; i < btts_pkg::NGRP; i++)
        begin
          if (avs_address_i == btts_pkg::OFS_GRP_BASE + 8'(i) * btts_pkg::GRP_STRIDE
                               + {4'h0, btts_pkg::OFS_G_CTRL})
          begin
            grp_q[i].dis <= avs_writedata_i[btts_pkg::G_DIS];
            grp_q[i].rd <= avs_writedata_i[btts_pkg::G_RD];
            grp_q[i].wr <= avs_writedata_i[btts_pkg::G_WR];
            grp_q[i].amode <= btts_pkg::btts_amode_t'(
                avs_writedata_i[btts_pkg::G_AMODE_LO +: 2]);
            grp_q[i].ddis <= avs_writedata_i[btts_pkg::G_DDIS];
            grp_q[i].ext <= btts_pkg::btts_ext_t'(avs_writedata_i[btts_pkg::G_EXT_LO +: 2]);
            grp_q[i].eref <= avs_writedata_i[btts_pkg::G_EREF_LO +: btts_pkg::EXT_W];
            grp_q[i].emask <= avs_writedata_i[btts_pkg::G_EMASK_LO +: btts_pkg::EXT_W];
          end
          else if (avs_address_i == btts_pkg::OFS_GRP_BASE
                   + 8'(i) * btts_pkg::GRP_STRIDE + {4'h0, btts_pkg::OFS_G_ADDR})
          begin
            grp_q[i].astart <= avs_writedata_i[15:0];
            grp_q[i].aend <= avs_writedata_i[31:16];
          end
          else if (avs_address_i == btts_pkg::OFS_GRP_BASE
                   + 8'(i) * btts_pkg::GRP_STRIDE + {4'h0, btts_pkg::OFS_G_DATA})
          begin
            grp_q[i].dref <= avs_writedata_i[15:0];
            grp_q[i].dmask <= avs_writedata_i[31:16];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Arming
  // ---------------------------------------------------------------------------
  logic armed_q, done_q, trig_q, wrap_q, halt_q, first_q;
  logic run_rise, run_fall, arm_evt;
  btts_pkg::btts_mode_t mode;
  btts_pkg::btts_seq_t seq_q;
  logic [POST_W-1:0] post_cnt_q;
  logic [IDX_W-1:0] wr_ptr_q;
  logic [IDX_W:0] count_q;

  assign mode = btts_pkg::btts_mode_t'(ctrl_q[btts_pkg::CTRL_MODE_LO +: 3]);
  assign run_rise = run_q && !run_prev_q;
  assign run_fall = !run_q && run_prev_q;
  assign arm_evt = cmd_arm || (ctrl_q[btts_pkg::CTRL_SELF_ARM] && run_rise);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      armed_q <= 1'b0;
    else if (clk_en_i)
    begin
      if (arm_evt)
        armed_q <= 1'b1;
      else if (cmd_disarm)
        armed_q <= 1'b0;
      else if (ctrl_q[btts_pkg::CTRL_SELF_ARM] && run_fall)
        armed_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Sampling and sequencer
  // ---------------------------------------------------------------------------
  logic sample, m0, m1, m2, any_m, hit, ends, store, full_end;

  // Manual disarm drops sampling at once and never touches halt_q
  assign sample = armed_q && !done_q && cyc_q.valid
                  && (!ctrl_q[btts_pkg::CTRL_RUN_ONLY] || run_q);
  assign m0 = grp_match(grp_q[0], cyc_q);
  assign m1 = grp_match(grp_q[1], cyc_q);
  assign m2 = grp_match(grp_q[2], cyc_q);
  assign any_m = m0 || m1 || m2;

  // Stop condition of the current cycle, before post counting
  always_comb
  begin
    hit = 1'b0;
    case (mode)
      btts_pkg::MD_ALL, btts_pkg::MD_EVENTS:
        hit = ctrl_q[btts_pkg::CTRL_POST_EN];
      btts_pkg::MD_A_C_NOT_B:
        hit = (seq_q == btts_pkg::SQ_STEP2) && !m1 && m2;
      btts_pkg::MD_ANY:
        hit = any_m;
      btts_pkg::MD_A_B_C:
        hit = (seq_q == btts_pkg::SQ_STEP3) && m2;
      btts_pkg::MD_AB_C:
        hit = (seq_q == btts_pkg::SQ_STEP2) && m2;
      default:
        hit = 1'b0;
    endcase
    hit = hit && ctrl_q[btts_pkg::CTRL_LOADED];
  end

  assign full_end = ctrl_q[btts_pkg::CTRL_FILL_ONCE] && (count_q == DEPTH_CNT - 1'b1);
  assign ends = sample && (full_end
                || (seq_q == btts_pkg::SQ_POST && post_cnt_q == post_cfg_q)
                || (seq_q != btts_pkg::SQ_POST && hit
                    && (!ctrl_q[btts_pkg::CTRL_POST_EN] || post_cfg_q == '0)));

  always_comb
  begin
    store = 1'b1;
    if (ctrl_q[btts_pkg::CTRL_LOADED] && mode == btts_pkg::MD_EVENTS)
      store = any_m;
    if (ctrl_q[btts_pkg::CTRL_EDGE_CAP] && (first_q || ends))
      store = 1'b1;
    store = store && sample;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      seq_q <= btts_pkg::SQ_STEP1;
      post_cnt_q <= '0;
      trig_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (arm_evt)
      begin
        seq_q <= btts_pkg::SQ_STEP1;
        post_cnt_q <= '0;
        trig_q <= 1'b0;
      end
      else if (sample && ctrl_q[btts_pkg::CTRL_LOADED])
      begin
        case (seq_q)
          btts_pkg::SQ_STEP1:
            if (hit)
            begin
              seq_q <= btts_pkg::SQ_POST;
              trig_q <= 1'b1;
              post_cnt_q <= POST_W'(1);
            end
            else if ((mode == btts_pkg::MD_A_C_NOT_B || mode == btts_pkg::MD_A_B_C) && m0)
              seq_q <= btts_pkg::SQ_STEP2;
            else if (mode == btts_pkg::MD_AB_C && (m0 || m1))
              seq_q <= btts_pkg::SQ_STEP2;
          btts_pkg::SQ_STEP2:
            if (hit)
            begin
              seq_q <= btts_pkg::SQ_POST;
              trig_q <= 1'b1;
              post_cnt_q <= POST_W'(1);
            end
            else if (mode == btts_pkg::MD_A_C_NOT_B && m1)
              seq_q <= btts_pkg::SQ_STEP1;
            else if (mode == btts_pkg::MD_A_B_C && m1)
              seq_q <= btts_pkg::SQ_STEP3;
          btts_pkg::SQ_STEP3:
            if (hit)
            begin
              seq_q <= btts_pkg::SQ_POST;
              trig_q <= 1'b1;
              post_cnt_q <= POST_W'(1);
            end
          btts_pkg::SQ_POST:
            post_cnt_q <= post_cnt_q + 1'b1;
          default:
            seq_q <= btts_pkg::SQ_STEP1;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // End of recording and halt request
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      done_q <= 1'b0;
      halt_q <= 1'b0;
      first_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      halt_q <= ends && ctrl_q[btts_pkg::CTRL_STOP_PROG];
      // An ending slot wins over a rearm landing in it
      if (ends)
        done_q <= 1'b1;
      else if (arm_evt)
        done_q <= 1'b0;
      if (arm_evt)
        first_q <= 1'b1;
      else if (sample)
        first_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Trace buffer
  // ---------------------------------------------------------------------------
  btts_pkg::btts_rec_t mem_q [DEPTH];
  logic [btts_pkg::TAG_W-1:0] tag_q;
  btts_pkg::btts_rec_t rec;

  // Free-running time tag, one tick per clock slot
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      tag_q <= '0;
    else if (clk_en_i)
      tag_q <= tag_q + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (clk_en_i && store)
      mem_q[wr_ptr_q] <= '{rnw: cyc_q.rnw, tag: tag_q, ext_b: cyc_q.ext_b,
                           ext_a: cyc_q.ext_a, addr: cyc_q.addr, data: cyc_q.data};
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_q <= '0;
      count_q <= '0;
      wrap_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (arm_evt)
      begin
        wr_ptr_q <= '0;
        count_q <= '0;
        wrap_q <= 1'b0;
      end
      else if (store)
      begin
        // Circular: oldest entry is overwritten after the wrap
        wr_ptr_q <= (wr_ptr_q == LAST_IDX) ? '0 : wr_ptr_q + 1'b1;
        if (count_q != DEPTH_CNT)
          count_q <= count_q + 1'b1;
        if (wr_ptr_q == LAST_IDX)
          wrap_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  assign rec = mem_q[rd_idx_q];

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      avs_readdata_o <= '0;
    else if (clk_en_i && avs_read_i && !ack_q)
    begin
      avs_readdata_o <= '0;
      if (avs_address_i == btts_pkg::OFS_CTRL)
        avs_readdata_o <= 32'(ctrl_q);
      else if (avs_address_i == btts_pkg::OFS_STATUS)
        avs_readdata_o <= {16'(count_q), 11'h000, wrap_q, trig_q,
                           done_q, armed_q && !done_q, armed_q};
      else if (avs_address_i == btts_pkg::OFS_POST)
        avs_readdata_o <= 32'(post_cfg_q);
      else if (avs_address_i == btts_pkg::OFS_RD_IDX)
        avs_readdata_o <= 32'(rd_idx_q);
      else if (avs_address_i == btts_pkg::OFS_REC_LO)
        avs_readdata_o <= {rec.addr, rec.data};
      else if (avs_address_i == btts_pkg::OFS_REC_HI)
        avs_readdata_o <= {rec.rnw, rec.tag, rec.ext_b, rec.ext_a};
      else if (avs_address_i == btts_pkg::OFS_WR_PTR)
        avs_readdata_o <= 32'(wr_ptr_q);
    end
  end

  assign halt_req_o = halt_q;
  assign recording_o = armed_q && !done_q;

endmodule : btts_top

`default_nettype wire

// ===== tb/btts_chk.sv
/* Port-level timing checker for btts_top, bound to every instance.
 * Assumes one clock and the synchronous active-low reset of the top. */
`timescale 1ns/1ps
`default_nettype none
module btts_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Target side
  input wire logic halt_req_o,
  input wire logic recording_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_open;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  chk_wait_start: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("waitrequest low in first access cycle");
  chk_rd_end: assert property (s_open ##0 avs_read_i |=> !avs_waitrequest_o)
    else $error("read not answered in second cycle");
  chk_wr_end: assert property (s_open ##0 avs_write_i |=> !avs_waitrequest_o)
    else $error("write not answered in second cycle");
  chk_rd_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  chk_rd_zero: assert property (avs_read_i && !avs_waitrequest_o
    && (avs_address_i >= 8'h20 || avs_address_i == 8'h04) |-> avs_readdata_o == 32'h0)
    else $error("write-only or unmapped place read nonzero");
  chk_halt_once: assert property (halt_req_o |=> !halt_req_o)
    else $error("halt request longer than one cycle");
  chk_halt_idle: assert property (halt_req_o |-> !recording_o)
    else $error("halt request while recording");
  chk_halt_cause: assert property (halt_req_o |-> $past(recording_o) || $past(recording_o, 2))
    else $error("halt request without recording ending");
endmodule : btts_chk
bind btts_top btts_chk btts_chk_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .halt_req_o(halt_req_o), .recording_o(recording_o));
`default_nettype wire

// ===== tb/btts_bus_model.sv
/* Behavioural observed target bus: bus cycles and the program-run level.
 * Assumes callers enter its tasks from the bench's main process. */
`timescale 1ns/1ps
`default_nettype none
module btts_bus_model (
  // Clock
  input wire logic clk_i,
  // Toward the analyzer
  output btts_pkg::btts_cycle_t cyc_o,
  output logic run_o
);
  initial
  begin
    cyc_o = '0;
    run_o = 1'b0;
  end
  task automatic run(input logic r);
    @(posedge clk_i);
    run_o <= r;
  endtask : run
  // Released bus shows inverted lines so stale values cannot match
  task automatic put(input logic rnw, input logic [15:0] a, input logic [15:0] d, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      cyc_o <= '{1'b1, rnw, a + i[15:0], d, 8'h5A, 8'hC3};
    end
    @(posedge clk_i);
    cyc_o <= '{1'b0, ~rnw, ~a, ~d, 8'hA5, 8'h3C};
  endtask : put
endmodule : btts_bus_model
`default_nettype wire

// ===== tb/btts_top_tb.sv
/* Self-checking bench for btts_top with the target bus model.
 * Assumes the package, top, model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module btts_top_tb;
  typedef struct packed {
    logic we;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } btts_row_t;
  localparam int DEPTH = 16;
  logic clk_i;
  logic reset_n_i;
  logic [7:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  btts_pkg::btts_cycle_t bus_cycle_i;
  logic prog_running_i;
  logic halt_req_o;
  logic recording_o;
  logic [31:0] q;
  int num_errors = 0;
  int check_count = 0;
  int halts = 0;
  int cycles = 0;
  btts_row_t rows [6] = '{'{1'b0, 8'h00, 32'h0, 32'h0000_000D},
    '{1'b1, 8'h0C, 32'h0000_0003, 32'h0000_0003}, '{1'b1, 8'h30, 32'hFFFF_FFFF, 32'h0},
    '{1'b0, 8'h04, 32'h0, 32'h0}, '{1'b1, 8'h48, 32'h1234_5678, 32'h0},
    '{1'b1, 8'h00, 32'h0000_002A, 32'h0000_002A}};
  btts_top #(.DEPTH(DEPTH), .POST_W(16)) btts_top_inst (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .clk_en_i(1'b1), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .bus_cycle_i(bus_cycle_i), .prog_running_i(prog_running_i),
    .halt_req_o(halt_req_o), .recording_o(recording_o));
  btts_bus_model btts_bus_model_inst (.clk_i(clk_i), .cyc_o(bus_cycle_i),
    .run_o(prog_running_i));
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= ~w;
    avs_write_i <= w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask : acc
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Hang guard, far above the run's need
  always @(posedge clk_i)
  begin
    cycles++;
    if (halt_req_o === 1'b1)
      halts++;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    reset_n_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (rows[i])
    begin
      if (rows[i].we)
        acc(1'b1, rows[i].a, rows[i].d, q);
      acc(1'b0, rows[i].a, 32'h0, q);
      chk("register", rows[i].e, q);
    end
    reset_n_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    btts_bus_model_inst.run(1'b1);
    repeat (4) @(posedge clk_i);
    btts_bus_model_inst.put(1'b1, 16'h1000, 16'hA000, 4);
    repeat (6) @(posedge clk_i);
    chk("recording", 32'h1, {31'h0, recording_o});
    btts_bus_model_inst.run(1'b0);
    repeat (8) @(posedge clk_i);
    chk("recording", 32'h0, {31'h0, recording_o});
    acc(1'b0, 8'h08, 32'h0, q);
    chk("count", 32'h4, {16'h0, q[31:16]});
    acc(1'b1, 8'h10, 32'h0, q);
    acc(1'b0, 8'h14, 32'h0, q);
    chk("record", 32'h1000_A000, q);
    acc(1'b0, 8'h18, 32'h0, q);
    chk("record", 32'h8000_C35A, q & 32'h8000_FFFF);
    acc(1'b1, 8'h04, 32'h1, q);
    btts_bus_model_inst.put(1'b1, 16'h2000, 16'h0, 2);
    repeat (6) @(posedge clk_i);
    acc(1'b0, 8'h08, 32'h0, q);
    chk("count", 32'h0, {16'h0, q[31:16]});
    acc(1'b1, 8'h04, 32'h2, q);
    // Group A: reads of one address, data and external terms off
    acc(1'b1, 8'h40, 32'h0000_002A, q);
    acc(1'b1, 8'h44, 32'h0000_1234, q);
    acc(1'b1, 8'h00, 32'h0000_02E0, q);
    acc(1'b1, 8'h04, 32'h1, q);
    btts_bus_model_inst.put(1'b0, 16'h1234, 16'h0, 1);
    btts_bus_model_inst.put(1'b1, 16'h1235, 16'h0, 1);
    repeat (6) @(posedge clk_i);
    chk("recording", 32'h1, {31'h0, recording_o});
    halts = 0;
    btts_bus_model_inst.put(1'b1, 16'h1234, 16'h0, 1);
    repeat (8) @(posedge clk_i);
    chk("recording", 32'h0, {31'h0, recording_o});
    chk("halts", 32'h1, halts);
    acc(1'b1, 8'h04, 32'h1, q);
    repeat (4) @(posedge clk_i);
    chk("recording", 32'h1, {31'h0, recording_o});
    acc(1'b1, 8'h04, 32'h2, q);
    repeat (4) @(posedge clk_i);
    chk("recording", 32'h0, {31'h0, recording_o});
    chk("halts", 32'h1, halts);
    for (int f = 1; f >= 0; f--)
    begin
      acc(1'b1, 8'h00, f ? 32'h0000_0202 : 32'h0000_0200, q);
      acc(1'b1, 8'h04, 32'h1, q);
      if (f)
        btts_bus_model_inst.put(1'b1, 16'h0, 16'h0, DEPTH + 4);
      else
        repeat (DEPTH + 4) btts_bus_model_inst.put(1'b1, 16'h0, 16'h0, 1);
      repeat (6) @(posedge clk_i);
      acc(1'b0, 8'h08, 32'h0, q);
      chk("wrapped", 32'h1, {31'h0, q[4]});
      chk("recording", {31'h0, ~f[0]}, {31'h0, recording_o});
      if (f)
        chk("count", 32'(DEPTH), {16'h0, q[31:16]});
    end
    // Three-step order, groups B and C take any read, post count of two
    acc(1'b1, 8'h50, 32'h0000_0002, q);
    acc(1'b1, 8'h60, 32'h0000_0002, q);
    acc(1'b1, 8'h0C, 32'h0000_0002, q);
    acc(1'b1, 8'h00, 32'h0000_0310, q);
    acc(1'b1, 8'h04, 32'h1, q);
    btts_bus_model_inst.put(1'b1, 16'h1234, 16'h0, 4);
    repeat (6) @(posedge clk_i);
    chk("recording", 32'h1, {31'h0, recording_o});
    btts_bus_model_inst.put(1'b1, 16'h0, 16'h0, 1);
    repeat (6) @(posedge clk_i);
    chk("recording", 32'h0, {31'h0, recording_o});
    summarize();
  end
endmodule : btts_top_tb
`default_nettype wire
